/* File: rtl/usb_irq_pkg.sv */
package usb_irq_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12; // byte address width seen by the slave
	localparam int DATA_W = 32; // apb data width

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_MASK_SET = 12'h000; // write-one-to-set mask
	localparam logic [11:0] OFF_MASK_CLR = 12'h004; // write-one-to-clear mask
	localparam logic [11:0] OFF_MASKED = 12'h008; // sources anded with mask
	localparam logic [11:0] OFF_MASK_VIEW = 12'h00C; // mask readback
	localparam logic [11:0] OFF_EOI = 12'h010; // end of interrupt vector
	localparam logic [11:0] OFF_DMA_CTRL = 12'h014; // transmit dma control
	localparam logic [11:0] OFF_TEARDOWN = 12'h018; // transmit dma teardown

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int CORE_LSB = 16; // core sources in bits 24-16
	localparam int CORE_W = 9;
	localparam int RX_LSB = 9; // receive endpoints in bits 12-9
	localparam int RX_W = 4;
	localparam int TX_LSB = 0; // transmit endpoints in bits 4-0
	localparam int TX_W = 5;
	localparam int MASK_W = CORE_W + RX_W + TX_W; // packed {core, rx, tx}
	localparam int EOI_LSB = 0; // vector in bits 7-0
	localparam int EOI_W = 8;
	localparam int DMA_EN_BIT = 0; // dma enable in bit 0
	localparam int TD_READY_BIT = 31; // teardown ready in bit 31
	localparam int TD_CHAN_LSB = 0; // teardown channel in bits 1-0
	localparam int TD_CHAN_W = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [MASK_W-1:0] MASK_RST = 18'h00000;
	localparam logic [EOI_W-1:0] EOI_RST = 8'h00;
	localparam logic DMA_EN_RST = 1'b0;
	localparam logic [TD_CHAN_W-1:0] TD_CHAN_RST = 2'h0;

	// teardown sequencer states, one-hot
	typedef enum logic [1:0] {
		TD_IDLE = 2'b01,
		TD_BUSY = 2'b10
	} td_state_t;

	// pull the three source fields out of a bus word
	function automatic logic [MASK_W-1:0] mask_from_word(input logic [DATA_W-1:0] w);
		return {w[CORE_LSB +: CORE_W], w[RX_LSB +: RX_W], w[TX_LSB +: TX_W]};
	endfunction : mask_from_word

	// place a packed mask vector back at its bus positions, rest zero
	function automatic logic [DATA_W-1:0] word_from_mask(input logic [MASK_W-1:0] m);
		logic [DATA_W-1:0] w;
		w = '0;
		w[CORE_LSB +: CORE_W] = m[MASK_W-1 -: CORE_W];
		w[RX_LSB +: RX_W] = m[TX_W +: RX_W];
		w[TX_LSB +: TX_W] = m[0 +: TX_W];
		return w;
	endfunction : word_from_mask

endpackage : usb_irq_pkg

/* File: rtl/tx_dma_teardown_unit.sv */
`timescale 1ns/100ps
module tx_dma_teardown_unit (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wr_req, // completed bus write to teardown register
	input wire logic [usb_irq_pkg::TD_CHAN_W-1:0] wr_chan, // channel written
	input wire logic td_done, // dma engine finished the teardown
	output logic ready, // register may be written
	output logic [usb_irq_pkg::TD_CHAN_W-1:0] chan, // channel held
	output logic td_req // one-cycle request to the dma engine
);

	// ----------------------------------------------------------------
	// teardown sequencer
	// ----------------------------------------------------------------
	usb_irq_pkg::td_state_t state_r, state_nxt; // idle means ready
	logic [usb_irq_pkg::TD_CHAN_W-1:0] chan_r, chan_nxt; // selected channel
	logic td_req_r, td_req_nxt; // request pulse

	// next state: a write while busy is dropped, so the held channel
	// can never change under a teardown in flight
	always_comb begin
		state_nxt = state_r;
		chan_nxt = chan_r;
		td_req_nxt = 1'b0;
		case (state_r)
			usb_irq_pkg::TD_IDLE: begin
				// R8: accept only while ready
				if (wr_req) begin
					state_nxt = usb_irq_pkg::TD_BUSY;
					// R9: capture the channel
					chan_nxt = wr_chan;
					td_req_nxt = 1'b1;
				end
			end
			usb_irq_pkg::TD_BUSY: begin
				// completion brings ready back
				if (td_done) begin
					state_nxt = usb_irq_pkg::TD_IDLE;
				end
			end
			default: begin
				state_nxt = usb_irq_pkg::TD_IDLE;
			end
		endcase
	end

	// registers only; R11: ready set and channel zero after reset
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_r <= usb_irq_pkg::TD_IDLE;
			chan_r <= usb_irq_pkg::TD_CHAN_RST;
			td_req_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			chan_r <= chan_nxt;
			td_req_r <= td_req_nxt;
		end
	end

	assign ready = state_r[0];
	assign chan = chan_r;
	assign td_req = td_req_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_TD_READY_GATE: assert property (@(posedge core_clk) disable iff (reset) // R8
		td_req_r |-> $past(state_r) == usb_irq_pkg::TD_IDLE && state_r == usb_irq_pkg::TD_BUSY)
		else $error("teardown request issued while not ready");
	AST_TD_CHAN_HOLD: assert property (@(posedge core_clk) disable iff (reset) // R9
		wr_req && state_r == usb_irq_pkg::TD_IDLE |=> chan_r == $past(wr_chan) && td_req_r)
		else $error("teardown channel not captured");

endmodule : tx_dma_teardown_unit

/* File: rtl/usb_irq_mask_and_tx_dma_ctrl.sv */
// What this block does
// R1: write one clears matching core mask bit
// R2: write one clears matching receive mask bit
// R3: write one clears matching transmit mask bit
// R4: masked view is sources and mask, read-only
// R5: writing zero vector ends non-dma interrupt
// R6: bit zero enables the transmit dma
// R7: software sets up descriptors before enabling
// R8: ready flag shows teardown may be written
// R9: channel field picks one of four channels
// R10: each mask bit passes or blocks source
// R11: reset ready one, channel zero; zeros ignored
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module usb_irq_mask_and_tx_dma_ctrl (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [usb_irq_pkg::ADDR_W-1:0] paddr,
	input wire logic [usb_irq_pkg::DATA_W-1:0] pwdata,
	output logic [usb_irq_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [usb_irq_pkg::CORE_W-1:0] core_src, // raw core sources
	input wire logic [usb_irq_pkg::RX_W-1:0] rx_src, // raw receive sources
	input wire logic [usb_irq_pkg::TX_W-1:0] tx_src, // raw transmit sources
	output logic [usb_irq_pkg::CORE_W-1:0] core_masked,
	output logic [usb_irq_pkg::RX_W-1:0] rx_masked,
	output logic [usb_irq_pkg::TX_W-1:0] tx_masked,
	output logic nondma_eoi, // one-cycle end of interrupt
	output logic tx_dma_enable, // level gate to the dma engine
	output logic td_req, // one-cycle teardown request
	output logic [usb_irq_pkg::TD_CHAN_W-1:0] td_channel,
	input wire logic td_done // dma engine finished teardown
);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic bus_done; // completing access edge
	logic wr_done; // completing write
	logic [usb_irq_pkg::MASK_W-1:0] src_vec; // packed raw sources
	logic [usb_irq_pkg::MASK_W-1:0] wr_vec; // packed write data
	logic td_ready; // teardown may be written
	logic [usb_irq_pkg::TD_CHAN_W-1:0] td_chan; // held channel
	// state registers are declared here, ahead of the decode that reads them
	logic pready_r, pready_nxt; // access completes
	logic pslverr_r, pslverr_nxt; // error response
	logic [usb_irq_pkg::DATA_W-1:0] prdata_r, prdata_nxt; // read data
	logic [usb_irq_pkg::MASK_W-1:0] mask_r, mask_nxt; // packed {core, rx, tx}
	logic [usb_irq_pkg::MASK_W-1:0] masked_r, masked_nxt; // registered view
	logic [usb_irq_pkg::EOI_W-1:0] eoi_vec_r, eoi_vec_nxt; // last vector written
	logic eoi_pulse_r, eoi_pulse_nxt; // acknowledge pulse
	logic dma_en_r, dma_en_nxt; // dma gate

	// true for every offset that has a register behind it
	function automatic logic addr_known(input logic [usb_irq_pkg::ADDR_W-1:0] a);
		return a == usb_irq_pkg::OFF_MASK_SET || a == usb_irq_pkg::OFF_MASK_CLR ||
			a == usb_irq_pkg::OFF_MASKED || a == usb_irq_pkg::OFF_MASK_VIEW ||
			a == usb_irq_pkg::OFF_EOI || a == usb_irq_pkg::OFF_DMA_CTRL ||
			a == usb_irq_pkg::OFF_TEARDOWN;
	endfunction : addr_known

	assign bus_done = psel && penable && pready_r;
	assign wr_done = bus_done && pwrite;
	assign src_vec = {core_src, rx_src, tx_src};
	assign wr_vec = usb_irq_pkg::mask_from_word(pwdata);

	// ----------------------------------------------------------------
	// apb slave: one wait state, read data registered
	// ----------------------------------------------------------------
	// ready rises in the second access cycle; read data and error are
	// prepared one cycle ahead so they come straight from flops
	always_comb begin
		pready_nxt = psel && penable && !pready_r;
		pslverr_nxt = 1'b0;
		prdata_nxt = '0;
		if (pready_nxt) begin
			// unmapped or misaligned address answers with an error
			pslverr_nxt = !addr_known(paddr);
			if (!pwrite) begin
				case (paddr)
					// R4: read-only masked view, reserved zero
					usb_irq_pkg::OFF_MASKED: begin
						prdata_nxt = usb_irq_pkg::word_from_mask(src_vec & mask_r);
					end
					usb_irq_pkg::OFF_MASK_VIEW: begin
						prdata_nxt = usb_irq_pkg::word_from_mask(mask_r);
					end
					usb_irq_pkg::OFF_EOI: begin
						prdata_nxt[usb_irq_pkg::EOI_LSB +: usb_irq_pkg::EOI_W] = eoi_vec_r;
					end
					usb_irq_pkg::OFF_DMA_CTRL: begin
						prdata_nxt[usb_irq_pkg::DMA_EN_BIT] = dma_en_r;
					end
					// R8: ready flag readable in the top bit
					usb_irq_pkg::OFF_TEARDOWN: begin
						prdata_nxt[usb_irq_pkg::TD_READY_BIT] = td_ready;
						prdata_nxt[usb_irq_pkg::TD_CHAN_LSB +: usb_irq_pkg::TD_CHAN_W] = td_chan;
					end
					// mask clear and set are write-only and read zero
					default: begin
						prdata_nxt = '0;
					end
				endcase
			end
		end
	end

	// bus response registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// interrupt mask and masked view
	// ----------------------------------------------------------------
	// only one register is addressed per write, so set and clear never meet
	always_comb begin
		mask_nxt = mask_r;
		if (wr_done && paddr == usb_irq_pkg::OFF_MASK_SET) begin
			mask_nxt = mask_r | wr_vec;
		end else if (wr_done && paddr == usb_irq_pkg::OFF_MASK_CLR) begin
			// R1: core field cleared by ones
			// R2: receive field cleared by ones
			// R3: transmit field cleared by ones
			// R11: zero bits leave the mask alone
			mask_nxt = mask_r & ~wr_vec;
		end
		// R10: mask gates each source
		masked_nxt = src_vec & mask_r;
	end

	// mask registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mask_r <= usb_irq_pkg::MASK_RST;
			masked_r <= '0;
		end else begin
			mask_r <= mask_nxt;
			masked_r <= masked_nxt;
		end
	end

	// ----------------------------------------------------------------
	// end of interrupt and dma control
	// ----------------------------------------------------------------
	// a nonzero vector is stored but acknowledges nothing
	always_comb begin
		eoi_vec_nxt = eoi_vec_r;
		eoi_pulse_nxt = 1'b0;
		dma_en_nxt = dma_en_r;
		if (wr_done && paddr == usb_irq_pkg::OFF_EOI) begin
			eoi_vec_nxt = pwdata[usb_irq_pkg::EOI_LSB +: usb_irq_pkg::EOI_W];
			// R5: zero write ends the interrupt
			eoi_pulse_nxt = pwdata[usb_irq_pkg::EOI_LSB +: usb_irq_pkg::EOI_W] == usb_irq_pkg::EOI_RST;
		end
		// R6: bit zero drives the gate
		if (wr_done && paddr == usb_irq_pkg::OFF_DMA_CTRL) begin
			dma_en_nxt = pwdata[usb_irq_pkg::DMA_EN_BIT];
		end
	end

	// control registers; enable order is software's business, the gate
	// follows the bit at once
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			eoi_vec_r <= usb_irq_pkg::EOI_RST;
			eoi_pulse_r <= 1'b0;
			dma_en_r <= usb_irq_pkg::DMA_EN_RST;
		end else begin
			eoi_vec_r <= eoi_vec_nxt;
			eoi_pulse_r <= eoi_pulse_nxt;
			dma_en_r <= dma_en_nxt;
		end
	end

	// ----------------------------------------------------------------
	// teardown
	// ----------------------------------------------------------------
	tx_dma_teardown_unit u_teardown (
		.core_clk(core_clk),
		.reset(reset),
		.wr_req(wr_done && paddr == usb_irq_pkg::OFF_TEARDOWN),
		.wr_chan(pwdata[usb_irq_pkg::TD_CHAN_LSB +: usb_irq_pkg::TD_CHAN_W]),
		.td_done(td_done),
		.ready(td_ready),
		.chan(td_chan),
		.td_req(td_req)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign core_masked = masked_r[usb_irq_pkg::MASK_W-1 -: usb_irq_pkg::CORE_W];
	assign rx_masked = masked_r[usb_irq_pkg::TX_W +: usb_irq_pkg::RX_W];
	assign tx_masked = masked_r[0 +: usb_irq_pkg::TX_W];
	assign nondma_eoi = eoi_pulse_r;
	assign tx_dma_enable = dma_en_r;
	assign td_channel = td_chan;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_CLR_CORE: assert property (@(posedge core_clk) disable iff (reset) // R1
		wr_done && paddr == usb_irq_pkg::OFF_MASK_CLR |=>
		(mask_r[17:9] & $past(wr_vec[17:9])) == 9'h000)
		else $error("core mask bit survived a clear");
	AST_CLR_RX: assert property (@(posedge core_clk) disable iff (reset) // R2
		wr_done && paddr == usb_irq_pkg::OFF_MASK_CLR |=> (mask_r[8:5] & $past(wr_vec[8:5])) == 4'h0)
		else $error("receive mask bit survived a clear");
	AST_CLR_TX: assert property (@(posedge core_clk) disable iff (reset) // R3
		wr_done && paddr == usb_irq_pkg::OFF_MASK_CLR |=> (mask_r[4:0] & $past(wr_vec[4:0])) == 5'h00)
		else $error("transmit mask bit survived a clear");
	AST_CLR_KEEP: assert property (@(posedge core_clk) disable iff (reset) // R11
		wr_done && paddr == usb_irq_pkg::OFF_MASK_CLR |=> (mask_r & ~$past(wr_vec)) == ($past(mask_r) & ~$past(wr_vec)))
		else $error("clear disturbed a bit written as zero");
	AST_MASKED_READ: assert property (@(posedge core_clk) disable iff (reset) // R4
		bus_done && !pwrite && paddr == usb_irq_pkg::OFF_MASKED |->
		prdata_r == usb_irq_pkg::word_from_mask($past(src_vec) & $past(mask_r)))
		else $error("masked view read wrong value");
	AST_MASK_GATE: assert property (@(posedge core_clk) disable iff (reset) // R10
		##1 masked_r == ($past(src_vec) & $past(mask_r)))
		else $error("masked output does not follow mask");
	AST_EOI_PULSE: assert property (@(posedge core_clk) disable iff (reset) // R5
		wr_done && paddr == usb_irq_pkg::OFF_EOI && pwdata[7:0] == 8'h00 |=> eoi_pulse_r ##1 !eoi_pulse_r)
		else $error("zero vector write gave no single pulse");
	AST_DMA_EN: assert property (@(posedge core_clk) disable iff (reset) // R6
		wr_done && paddr == usb_irq_pkg::OFF_DMA_CTRL |=> tx_dma_enable == $past(pwdata[0]))
		else $error("dma enable does not follow bit zero");
	AST_READY_BUS: assert property (@(posedge core_clk) disable iff (reset) // apb ready lasts one cycle
		pready_r |=> !pready_r)
		else $error("ready held beyond one cycle");

endmodule : usb_irq_mask_and_tx_dma_ctrl

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic core_clk;
	logic reset;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [8:0] core_src;
	logic [3:0] rx_src;
	logic [4:0] tx_src;
	logic [8:0] core_masked;
	logic [3:0] rx_masked;
	logic [4:0] tx_masked;
	logic nondma_eoi;
	logic tx_dma_enable;
	logic td_req;
	logic [1:0] td_channel;
	logic td_done;
	int bad_count = 0; // mismatches seen
	int checked = 0; // comparisons made
	int eoi_seen = 0; // end of interrupt pulses counted
	int td_seen = 0; // teardown request pulses counted
	logic [31:0] rd; // last read word
	logic err; // last error response

	usb_irq_mask_and_tx_dma_ctrl DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_src(core_src), .rx_src(rx_src), .tx_src(tx_src), .core_masked(core_masked), .rx_masked(rx_masked),
		.tx_masked(tx_masked), .nondma_eoi(nondma_eoi), .tx_dma_enable(tx_dma_enable), .td_req(td_req),
		.td_channel(td_channel), .td_done(td_done));

	// ----------------------------------------------------------------
	// clock, pulse counters, watchdog
	// ----------------------------------------------------------------
	// 125 mhz core clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// one-cycle pulses are counted so that a stuck-high pulse shows as extra counts
	always @(posedge core_clk) begin
		if (nondma_eoi === 1'b1) eoi_seen++;
		if (td_req === 1'b1) td_seen++;
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// one apb transfer; an idle edge before setup keeps release and setup apart
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) chk({31'h0, pready}, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	// masked outputs settle one cycle after a change, two edges are given
	task automatic outchk(input logic [31:0] exp);
		repeat (2) @(posedge core_clk);
		chk({14'h0, core_masked, rx_masked, tx_masked}, exp);
	endtask : outchk

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		core_src = 9'h1FF;
		rx_src = 4'hF;
		tx_src = 5'h1F;
		td_done = 1'b0;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		// reset values of the teardown, control and vector registers
		rdchk(12'h018, 32'h80000000);
		rdchk(12'h014, 32'h00000000);
		rdchk(12'h010, 32'h00000000);
		rdchk(12'h008, 32'h00000000);
		// open every mask, all sources pass; reserved bits read zero
		wr(12'h000, 32'hFFFFFFFF);
		rdchk(12'h008, 32'h01FF1E1F);
		outchk(32'h0003FFFF);
		// writing zeros to the clear port changes nothing
		wr(12'h004, 32'h00000000);
		rdchk(12'h00C, 32'h01FF1E1F);
		// clear a few bits in each field, one field at a time
		wr(12'h004, 32'h00AA0000);
		rdchk(12'h008, 32'h01551E1F);
		wr(12'h004, 32'h00000A00);
		rdchk(12'h008, 32'h0155141F);
		wr(12'h004, 32'h00000015);
		rdchk(12'h008, 32'h0155140A);
		rdchk(12'h004, 32'h00000000);
		outchk({14'h0, 9'h155, 4'hA, 5'h0A});
		// sources now partly low: the view follows src and mask
		core_src <= 9'h0F0;
		rx_src <= 4'h3;
		tx_src <= 5'h18;
		outchk({14'h0, 9'h050, 4'h2, 5'h08});
		rdchk(12'h008, 32'h00500408);
		// the masked view ignores writes
		wr(12'h008, 32'hFFFFFFFF);
		rdchk(12'h008, 32'h00500408);
		// a nonzero vector is stored quietly, a zero write ends the interrupt
		wr(12'h010, 32'hFFFFFF5A);
		rdchk(12'h010, 32'h0000005A);
		chk(eoi_seen, 32'h0);
		wr(12'h010, 32'h00000000);
		repeat (3) @(posedge core_clk);
		chk(eoi_seen, 32'h1);
		// dma enable follows bit zero only
		// descriptor setup taken as done
		wr(12'h014, 32'h00000001);
		@(posedge core_clk);
		chk({31'h0, tx_dma_enable}, 32'h1);
		rdchk(12'h014, 32'h00000001);
		wr(12'h014, 32'hFFFFFFFE);
		@(posedge core_clk);
		chk({31'h0, tx_dma_enable}, 32'h0);
		rdchk(12'h014, 32'h00000000);
		// teardown of each channel, with a refused write while busy
		for (int c = 0; c < 4; c++) begin
			wr(12'h018, 32'h7FFFFFFC | c);
			@(posedge core_clk);
			chk({30'h0, td_channel}, c);
			rdchk(12'h018, c);
			wr(12'h018, 32'h00000003 ^ c);
			rdchk(12'h018, c);
			@(posedge core_clk);
			td_done <= 1'b1;
			@(posedge core_clk);
			td_done <= 1'b0;
			repeat (2) @(posedge core_clk);
			rdchk(12'h018, 32'h80000000 | c);
		end
		chk(td_seen, 32'h4);
		// unmapped address gives an error and reads zero
		xfer(1'b0, 12'h020, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		// a second reset mid-run restores the ready flag and clears the masks
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rdchk(12'h018, 32'h80000000);
		rdchk(12'h008, 32'h00000000);
		give_verdict();
	end

endmodule : tb_top
